// ==== src/sps_defines.vh ====
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH
// ==========================================
// sequencer geometry
`define SPS_POS_W 6
`define SPS_POS_MAX 6'h3F
// position step per edge for each excitation mode (finest resolution is 1/64 turn of the pattern)
`define SPS_STEP_FULL 7'h10
`define SPS_STEP_HALF 7'h08
`define SPS_STEP_W12 7'h04
`define SPS_STEP_2W12 7'h02
`define SPS_STEP_4W12 7'h01
// ==========================================
// fault type encoding on fault_type_level
`define SPS_FT_NONE 2'h0
`define SPS_FT_OPEN 2'h1
`define SPS_FT_OVERCUR 2'h2
`define SPS_FT_OVERHEAT 2'h3
// ==========================================
// timing
`define SPS_CLK_NS 25
`define SPS_POR_NS 1000
`define SPS_POR_CYC ((`SPS_POR_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`define SPS_POR_W 6
`endif

// ==== src/sps_sync.v ====
`timescale 1ns/1ps
// ==========================================
// two-flop synchroniser for a bus of levels
module sps_sync #(parameter W = 1)
(
   input wire core_clk, // system clock
   input wire rst, // async reset
   input wire [W-1:0] async_in, // raw input levels
   output reg [W-1:0] sync_out // synchronised levels
);
   reg [W-1:0] meta;
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         meta <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// ==== src/sps_top.v ====
`timescale 1ns/1ps
`include "sps_defines.vh"
module sps_top
(
   input wire core_clk, // 40 MHz system clock
   input wire rst, // power-on reset, async active high
   input wire system_reset_n, // external reset pin, active low
   input wire step_clk, // step clock from controller
   input wire rotation_direction, // 0 cw, 1 ccw
   input wire excitation_select_lo, // mode select bit 0
   input wire excitation_select_hi, // mode select bit 1
   input wire step_edge_select, // 1 rising only, 0 both edges
   input wire enable, // high runs, low cuts current
   input wire chop_off_phase, // high during chopping off-time
   input wire flyback_seen, // flyback current sensed this off-time
   input wire overcurrent_trip, // overcurrent comparator
   input wire overheat_trip, // substrate overheat comparator
   output reg phase_a, // phase A drive
   output reg phase_ab, // phase A-bar drive
   output reg phase_b, // phase B drive
   output reg phase_bb, // phase B-bar drive
   output reg [5:0] current_level, // current setting index along sine, 0..15
   output reg excitation_monitor_out, // excitation monitor
   output wire any_fault_n_out, // fault drive value, always 0
   output wire any_fault_n_oe, // open-drain enable, high pulls low
   output reg [1:0] fault_type_level // 0 none,1 open,2 overcurrent,3 overheat
);
   // ==========================================
   // reset forming
   wire ext_s;
   reg [`SPS_POR_W-1:0] por_cnt;
   reg sys_rst;
   sps_sync #(.W(1)) u_rsync
   (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(system_reset_n),
      .sync_out(ext_s)
   );
   // stretch power-on reset so the sequencer sees a clean release
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         por_cnt <= {`SPS_POR_W{1'b0}};
         sys_rst <= 1'b1;
      end
      else
      begin
         if (por_cnt != `SPS_POR_CYC)
            por_cnt <= por_cnt + 1'b1;
         sys_rst <= (por_cnt != `SPS_POR_CYC) | ~ext_s;
      end
   end
   // ==========================================
   // input synchronisation
   wire [4:0] in_s;
   sps_sync #(.W(5)) u_isync
   (
      .core_clk(core_clk),
      .rst(rst),
      .async_in({step_clk, rotation_direction, excitation_select_hi, excitation_select_lo, step_edge_select}),
      .sync_out(in_s)
   );
   wire step_s = in_s[4];
   wire dir_s = in_s[3];
   wire [1:0] mode_s = in_s[2:1];
   wire edge_s = in_s[0];
   reg step_d;
   reg [`SPS_POS_W-1:0] pos;
   reg fault_open, fault_oc, fault_oh;
   wire any_fault = fault_open | fault_oc | fault_oh;
   function [6:0] step_size;
      input [1:0] m;
      input e;
      begin
         case ({e, m})
            3'b100: step_size = `SPS_STEP_FULL;
            3'b101: step_size = `SPS_STEP_HALF;
            3'b110: step_size = `SPS_STEP_W12;
            3'b111: step_size = `SPS_STEP_2W12;
            3'b000: step_size = `SPS_STEP_HALF;
            3'b001: step_size = `SPS_STEP_W12;
            3'b010: step_size = `SPS_STEP_2W12;
            default: step_size = `SPS_STEP_4W12;
         endcase
      end
   endfunction
   wire rise = step_s & ~step_d;
   // falling edge too when edge mode low
   wire fall = ~step_s & step_d & ~edge_s;
   wire [6:0] st = step_size(mode_s, edge_s);
   // full-step mode sits on odd half positions so both coils are driven (2-phase)
   wire [`SPS_POS_W-1:0] base = (edge_s && mode_s == 2'b00) ? (pos | 6'h08) & ~6'h07 : pos & ~(st[5:0] - 1'b1);
   reg [`SPS_POS_W-1:0] next_pos;
   always @*
   begin
      // keep position, snap down to legal point of new mode; full step takes the odd half of its quadrant
      if (dir_s)
         next_pos = base - st[5:0];
      else
         next_pos = base + st[5:0];
   end
   // ==========================================
   // sequencer
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         step_d <= 1'b0;
         pos <= 6'h00;
         excitation_monitor_out <= 1'b0;
      end
      else if (sys_rst)
      begin
         step_d <= step_s;
         pos <= 6'h00;
         excitation_monitor_out <= 1'b0;
      end
      // frozen while disabled, edge history held too
      else if (enable)
      begin
         step_d <= step_s;
         if (rise | fall)
         begin
            pos <= next_pos;
            // monitor marks each full pattern quadrant
            if (next_pos[3:0] == 4'h0 || (edge_s && mode_s == 2'b00 && next_pos[3:0] == 4'h8))
               excitation_monitor_out <= ~excitation_monitor_out;
         end
      end
   end
   // ==========================================
   // faults
   reg chop_d;
   reg fly_seen_win;
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         fault_open <= 1'b0;
         fault_oc <= 1'b0;
         fault_oh <= 1'b0;
         chop_d <= 1'b0;
         fly_seen_win <= 1'b0;
      end
      else if (sys_rst)
      begin
         fault_open <= 1'b0;
         fault_oc <= 1'b0;
         fault_oh <= 1'b0;
         chop_d <= 1'b0;
         fly_seen_win <= 1'b0;
      end
      else
      begin
         chop_d <= chop_off_phase;
         if (chop_off_phase & ~chop_d)
            fly_seen_win <= flyback_seen;
         else if (chop_off_phase & flyback_seen)
            fly_seen_win <= 1'b1;
         if (~chop_off_phase & chop_d & ~fly_seen_win & enable)
            fault_open <= 1'b1;
         if (overcurrent_trip)
            fault_oc <= 1'b1;
         if (overheat_trip)
            fault_oh <= 1'b1;
      end
   end
   assign any_fault_n_out = 1'b0;
   assign any_fault_n_oe = any_fault;
   // ==========================================
   // outputs
   wire [1:0] quad = pos[5:4];
   wire [3:0] sub = pos[3:0];
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         phase_a <= 1'b0;
         phase_ab <= 1'b0;
         phase_b <= 1'b0;
         phase_bb <= 1'b0;
         current_level <= 6'h00;
         fault_type_level <= `SPS_FT_NONE;
      end
      else
      begin
         // highest-priority fault type
         // cleared with the faults so the type never outlives the summary flag
         if (sys_rst)
            fault_type_level <= `SPS_FT_NONE;
         else if (fault_oh)
            fault_type_level <= `SPS_FT_OVERHEAT;
         else if (fault_oc)
            fault_type_level <= `SPS_FT_OVERCUR;
         else if (fault_open)
            fault_type_level <= `SPS_FT_OPEN;
         else
            fault_type_level <= `SPS_FT_NONE;
         current_level <= {2'b00, sub};
         // enable low cuts drive; fault cuts drive
         if (!enable || any_fault || sys_rst)
         begin
            phase_a <= 1'b0;
            phase_ab <= 1'b0;
            phase_b <= 1'b0;
            phase_bb <= 1'b0;
         end
         else
         begin
            phase_a <= (quad == 2'd0) | (quad == 2'd3 && sub != 4'h0);
            phase_b <= (quad == 2'd1) | (quad == 2'd0 && sub != 4'h0);
            phase_ab <= (quad == 2'd2) | (quad == 2'd1 && sub != 4'h0);
            phase_bb <= (quad == 2'd3) | (quad == 2'd2 && sub != 4'h0);
         end
      end
   end
endmodule

// ==== tb/sps_ctrl_model.sv ====
`timescale 1ns/1ps
// ==========================================
// motion controller
module sps_ctrl_model
(
   input wire core_clk, // clk
   output reg step_clk, // step
   output reg rotation_direction // dir
);
   initial
   begin
      step_clk = 1'b0;
      rotation_direction = 1'b0;
   end
   // dir set mid-level, 25 us levels
   task edge_go(input d);
   begin
      @(posedge core_clk) rotation_direction <= d;
      repeat (500) @(posedge core_clk);
      step_clk <= ~step_clk;
      repeat (500) @(posedge core_clk);
   end
   endtask
   // slow-down: each level lasts about 2*half cycles, half grows toward the stop
   task edge_ramp(input d, input integer half);
   begin
      @(posedge core_clk) rotation_direction <= d;
      repeat (half) @(posedge core_clk);
      step_clk <= ~step_clk;
      repeat (half) @(posedge core_clk);
   end
   endtask
endmodule

// ==== tb/sps_top_assertions.sv ====
`timescale 1ns/1ps
// ==========================================
// port checker
module sps_chk
(
   input wire core_clk, // clk
   input wire rst, // por
   input wire system_reset_n, // pin
   input wire step_clk, // step
   input wire step_edge_select, // edge
   input wire excitation_select_lo, // m0
   input wire excitation_select_hi, // m1
   input wire enable, // run
   input wire overcurrent_trip, // oc
   input wire overheat_trip, // heat
   input wire phase_a, // a
   input wire phase_ab, // ab
   input wire phase_b, // b
   input wire phase_bb, // bb
   input wire [5:0] current_level, // sub
   input wire any_fault_n_oe, // flag
   input wire [1:0] fault_type_level // kind
);
   reg [6:0] up;
   wire ok = (up == 7'h7F) && system_reset_n && enable;
   wire off = !(phase_a || phase_ab || phase_b || phase_bb);
   // por stretch must run out before fault kinds and current_level steps are judged
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
         up <= 7'h00;
      else if (up != 7'h7F)
         up <= up + 7'h01;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_dis; !enable [*3] |-> off; endproperty
   a_dis: assert property (p_dis) else $error("drive while disabled");
   property p_flag; fault_type_level != 2'h0 |-> any_fault_n_oe; endproperty
   a_flag: assert property (p_flag) else $error("flag missing");
   property p_off; any_fault_n_oe [*2] |-> off; endproperty
   a_off: assert property (p_off) else $error("drive with fault");
   property p_hold; system_reset_n [*6] ##0 any_fault_n_oe |=> any_fault_n_oe; endproperty
   a_hold: assert property (p_hold) else $error("fault dropped");
   property p_heat; ok [*6] ##0 overheat_trip |-> ##2 fault_type_level == 2'h3; endproperty
   a_heat: assert property (p_heat) else $error("heat kind");
   property p_oc; ok [*6] ##0 overcurrent_trip |-> ##2 fault_type_level[1]; endproperty
   a_oc: assert property (p_oc) else $error("oc kind");
   property p_fall;
      (ok && step_edge_select && !step_clk && $stable({excitation_select_hi, excitation_select_lo})) [*8]
         |-> $stable(current_level);
   endproperty
   a_fall: assert property (p_fall) else $error("moved on fall");
   property p_rise;
      $rose(step_clk) && ok && !any_fault_n_oe && (excitation_select_hi || excitation_select_lo)
         |-> ##[2:5] ($changed(current_level) || !enable);
   endproperty
   a_rise: assert property (p_rise) else $error("rise not taken");
endmodule
bind sps_top sps_chk chk (.core_clk, .rst, .system_reset_n, .step_clk, .step_edge_select, .excitation_select_lo,
   .excitation_select_hi, .enable, .overcurrent_trip, .overheat_trip, .phase_a, .phase_ab, .phase_b, .phase_bb,
   .current_level, .any_fault_n_oe, .fault_type_level);

// ==== tb/sps_top_tb_top.sv ====
`timescale 1ns/1ps
// ==========================================
// bench
module sps_top_tb_top;
   reg core_clk = 1'b0;
   reg rst = 1'b1;
   reg system_reset_n = 1'b1;
   reg step_edge_select = 1'b0;
   reg [1:0] mode = 2'h3;
   reg enable = 1'b0;
   reg chop = 1'b0;
   reg fly = 1'b0;
   reg oc = 1'b0;
   reg heat = 1'b0;
   wire step_clk, dir, pa, pab, pb, pbb, oe, mon, fault_drv;
   wire [5:0] lvl;
   wire [1:0] kind_o;
   integer error_cnt = 0;
   integer tests_run = 0;
   integer k;
   initial
   begin
      forever #12.5 core_clk = ~core_clk;
   end
   sps_ctrl_model ctrl (.core_clk(core_clk), .step_clk(step_clk), .rotation_direction(dir));
   sps_top uut (.core_clk(core_clk), .rst(rst), .system_reset_n(system_reset_n), .step_clk(step_clk),
      .rotation_direction(dir), .excitation_select_lo(mode[0]), .excitation_select_hi(mode[1]),
      .step_edge_select(step_edge_select), .enable(enable), .chop_off_phase(chop), .flyback_seen(fly),
      .overcurrent_trip(oc), .overheat_trip(heat), .phase_a(pa), .phase_ab(pab), .phase_b(pb), .phase_bb(pbb),
      .current_level(lvl), .excitation_monitor_out(mon), .any_fault_n_out(fault_drv), .any_fault_n_oe(oe),
      .fault_type_level(kind_o));
   task chk(input [5:0] seen, input [5:0] want);
   begin
      tests_run = tests_run + 1;
      if (seen !== want)
      begin
         error_cnt = error_cnt + 1;
         $display("mismatch at %0t: got %h want %h", $time, seen, want);
      end
   end
   endtask
   task give_verdict;
   begin
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   task t_both;
   begin
      ctrl.edge_go(1'b0);
      chk(lvl, 6'h01);
      ctrl.edge_go(1'b0);
      chk(lvl, 6'h02);
      ctrl.edge_go(1'b1);
      chk(lvl, 6'h01);
      @(posedge core_clk) enable <= 1'b0;
      ctrl.edge_go(1'b0);
      chk({2'h0, pa, pab, pb, pbb}, 6'h00);
      chk(lvl, 6'h01);
      @(posedge core_clk) enable <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk(lvl, 6'h02);
      $display("end both");
   end
   endtask
   task t_rise;
   begin
      @(posedge core_clk) step_edge_select <= 1'b1;
      ctrl.edge_go(1'b0);
      chk(lvl, 6'h04);
      ctrl.edge_go(1'b0);
      chk(lvl, 6'h04);
      // mode moves only far from step edges
      @(posedge core_clk) mode <= 2'h1;
      repeat (10) @(posedge core_clk);
      chk(lvl, 6'h04);
      ctrl.edge_go(1'b0);
      chk(lvl, 6'h08);
      @(posedge core_clk) mode <= 2'h0;
      repeat (10) @(posedge core_clk);
      chk(lvl, 6'h08);
      // slow down into the stop; the fall is ignored, the rise takes a full step
      ctrl.edge_ramp(1'b0, 600);
      ctrl.edge_ramp(1'b0, 700);
      chk(lvl, 6'h08);
      chk({2'h0, pa, pab, pb, pbb}, 6'h06);
      chk({5'h00, mon}, 6'h01);
      $display("end rise");
   end
   endtask
   task t_fault(input [1:0] kd);
   begin
      // chopping only long after enable rose
      @(posedge core_clk)
      begin
         chop <= (kd < 2'h2);
         fly <= (kd == 2'h0);
         oc <= (kd == 2'h2);
         heat <= (kd == 2'h3);
      end
      @(posedge core_clk)
      begin
         chop <= 1'b0;
         fly <= 1'b0;
         oc <= 1'b0;
         heat <= 1'b0;
      end
      repeat (20) @(posedge core_clk);
      chk({5'h00, oe}, {5'h00, kd != 2'h0});
      chk({5'h00, fault_drv}, 6'h00);
      chk({4'h0, kind_o}, {4'h0, kd});
      if (kd != 2'h0)
         chk({2'h0, pa, pab, pb, pbb}, 6'h00);
      @(posedge core_clk) system_reset_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      system_reset_n <= 1'b1;
      repeat (400) @(posedge core_clk);
      chk({3'h0, oe, kind_o}, 6'h00);
      chk(lvl, 6'h00);
      chk({5'h00, mon}, 6'h00);
      chk({2'h0, pa, pab, pb, pbb}, 6'h08);
      $display("end fault");
   end
   endtask
   initial
   begin
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      // enable late, first step 12.5 us on
      repeat (400) @(posedge core_clk);
      enable <= 1'b1;
      chk(lvl, 6'h00);
      t_both;
      t_rise;
      for (k = 0; k < 4; k = k + 1)
         t_fault(k[1:0]);
      give_verdict;
   end
   initial
   begin
      // run needs about 12k cycles
      repeat (40000) @(posedge core_clk);
      error_cnt = error_cnt + 1;
      give_verdict;
   end
endmodule
